// ### design/tgd_pkg.sv
// Constants and carrier types for the text and graphics display control.
package tgd_pkg;
	// ==============================================================
	// I/O port addresses
	localparam logic [9:0] MONO_CRTC_INDEX   = 10'h3b4;
	localparam logic [9:0] MONO_CRTC_DATA    = 10'h3b5;
	localparam logic [9:0] MONO_DISP_CONTROL = 10'h3b8;
	localparam logic [9:0] MONO_DISP_STATUS  = 10'h3ba;
	localparam logic [9:0] COLOR_CRTC_INDEX  = 10'h3d4;
	localparam logic [9:0] COLOR_CRTC_DATA   = 10'h3d5;
	localparam logic [9:0] COLOR_MODE_SELECT = 10'h3d8;
	localparam logic [9:0] COLOR_PAL_SELECT  = 10'h3d9;
	localparam logic [9:0] COLOR_DISP_STATUS = 10'h3da;
	// ==============================================================
	// Timing register indices
	localparam int NUM_CRTC = 18;
	localparam logic [4:0] IX_HORIZ_TOTAL     = 5'h00;
	localparam logic [4:0] IX_HORIZ_DISPLAYED = 5'h01;
	localparam logic [4:0] IX_HORIZ_SYNC_POS  = 5'h02;
	localparam logic [4:0] IX_HORIZ_SYNC_W    = 5'h03;
	localparam logic [4:0] IX_VERT_TOTAL      = 5'h04;
	localparam logic [4:0] IX_VERT_ADJUST     = 5'h05;
	localparam logic [4:0] IX_VERT_DISPLAYED  = 5'h06;
	localparam logic [4:0] IX_VERT_SYNC_POS   = 5'h07;
	localparam logic [4:0] IX_INTERLACE       = 5'h08;
	localparam logic [4:0] IX_MAX_SCAN_LINE   = 5'h09;
	localparam logic [4:0] IX_CURSOR_FIRST    = 5'h0a;
	localparam logic [4:0] IX_CURSOR_LAST     = 5'h0b;
	localparam logic [4:0] IX_START_HIGH      = 5'h0c;
	localparam logic [4:0] IX_START_LOW       = 5'h0d;
	localparam logic [4:0] IX_CURSOR_HIGH     = 5'h0e;
	localparam logic [4:0] IX_CURSOR_LOW      = 5'h0f;
	localparam logic [4:0] IX_PEN_HIGH        = 5'h10;
	localparam logic [4:0] IX_PEN_LOW         = 5'h11;
	// ==============================================================
	// Field positions
	localparam int MC_COLOR_EN = 0;
	localparam int MC_FG_FULL  = 1;
	localparam int MC_VIDEO_EN = 3;
	localparam int MC_BLANK_EN = 4;
	localparam int MC_BG_EN    = 5;
	localparam int MC_BG_FULL  = 6;
	localparam int MS_80COL    = 0;
	localparam int MS_GRAPHICS = 1;
	localparam int MS_BW       = 2;
	localparam int MS_VIDEO_EN = 3;
	localparam int MS_HIRES    = 4;
	localparam int MS_BLINK    = 5;
	localparam int PS_INTENSE  = 4;
	localparam int PS_SET1     = 5;
	localparam int CURSOR_BLINK_BIT = 3;
	localparam int CHAR_BLINK_BIT   = 4;
	// ==============================================================
	// Reset values and counts
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [5:0] MODE_RESET  = 6'h00;
	localparam logic [5:0] PAL_RESET   = 6'h00;
	localparam logic [4:0] VSYNC_LINES = 5'h10;
	localparam int BUF_BYTES = 16384;
	// ==============================================================
	// Types
	typedef enum logic [0:0] {
		TGD_V_ROWS   = 1'b0,
		TGD_V_ADJUST = 1'b1
	} tgd_vphase_e;
	typedef struct packed {
		logic [9:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} tgd_io_req_s;
	typedef struct packed {
		logic [3:0] irgb;
		logic       hsync;
		logic       vsync;
		logic       blank;
	} tgd_video_s;
endpackage

// ### design/tgd_display_control.sv
// Text and graphics display controller with timing registers and buffer.
//
// Function
// [RL1] Index port decoded at configured address
// [RL2] Data port moves indexed timing register
// [RL3] Host writes index before data access
// [RL4] Registers hold raster timing, cursor, start
// [RL5] Mono control bit 0 selects colour
// [RL6] Bits 1, 6 set full/half intensity
// [RL7] Mono control bit 3 gates video
// [RL8] Bits 4, 5 enable blanking, background
// [RL9] Mono status shows hsync and video
// [RL10] Mode bit 0 picks 80/40 columns
// [RL11] Mode bits pick graphics and black/white
// [RL12] Mode bit 3 enables video
// [RL13] Mode bit 4 selects 640x200 mode
// [RL14] Mode bit 5 turns intensity into blink
// [RL15] Palette IRGB gives border or background
// [RL16] Palette bit 4 intensifies graphics colours
// [RL17] Pixel codes map to palette sets
// [RL18] Palette bit 5 picks set; set 1 blue
// [RL19] Colour status shows enable and vsync
// [RL20] 16 KB buffer, per-adapter mapping
// [RL21] Text cell is code then attribute
// [RL22] Attribute decodes display and blink, intensity
// [RL23] Counters produce sync, enable and cursor
`timescale 1ns/1ps
module tgd_display_control (
	input  wire logic                clock,
	input  wire logic                reset,
	input  wire logic                colour_strap,
	input  wire logic                light_pen,
	input  wire tgd_pkg::tgd_io_req_s io_req,
	output logic [7:0]               io_rdata,
	input  wire logic [13:0]         mem_addr,
	input  wire logic                mem_wr,
	input  wire logic [7:0]          mem_wdata,
	output logic [7:0]               mem_rdata,
	output logic [7:0]               font_code,
	output logic [4:0]               font_line,
	input  wire logic [7:0]          font_bits,
	output tgd_pkg::tgd_video_s      video
);
	// ==============================================================
	// Pixel functions
	function automatic logic [3:0] text_irgb(input logic [7:0] attr,
		input logic on, input logic blink_mode);
		logic [3:0] bg;
		bg = {blink_mode ? 1'b0 : attr[7], attr[6:4]};
		if (attr[6:0] == 7'h00)
			text_irgb = 4'h0;
		else
			text_irgb = on ? {attr[3], attr[2:0]} : bg;
	endfunction

	function automatic logic [3:0] pal_irgb(input logic [1:0] code,
		input logic [5:0] pal);
		logic [2:0] rgb;
		rgb = 3'b000;
		case (code)
			2'b01: rgb = pal[tgd_pkg::PS_SET1] ? 3'b011 : 3'b010;
			2'b10: rgb = pal[tgd_pkg::PS_SET1] ? 3'b101 : 3'b100;
			2'b11: rgb = pal[tgd_pkg::PS_SET1] ? 3'b111 : 3'b110;
			default: rgb = 3'b000;
		endcase
		if (code == 2'b00)
			pal_irgb = pal[3:0];
		else
			pal_irgb = {pal[tgd_pkg::PS_INTENSE], rgb};
	endfunction

	// ==============================================================
	// Input synchronisers
	logic [2:0] strap_sync_reg;
	logic [2:0] pen_sync_reg;
	logic       colour_cfg_reg;
	logic       pen_level_reg;
	logic       pen_rise;

	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			strap_sync_reg <= 3'h0;
			pen_sync_reg   <= 3'h0;
			colour_cfg_reg <= 1'b0;
			pen_level_reg  <= 1'b0;
		end
		else
		begin
			strap_sync_reg <= {strap_sync_reg[1:0], colour_strap};
			pen_sync_reg   <= {pen_sync_reg[1:0], light_pen};
			if (strap_sync_reg[1] == strap_sync_reg[2])
				colour_cfg_reg <= strap_sync_reg[2];
			if (pen_sync_reg[1] == pen_sync_reg[2])
				pen_level_reg <= pen_sync_reg[2];
		end

	assign pen_rise = pen_sync_reg[1] & pen_sync_reg[2] & ~pen_level_reg;

	// ==============================================================
	// Port decode
	logic colour;
	logic idx_wr;
	logic data_wr;
	logic data_rd;
	logic ctrl_wr;
	logic mode_wr;
	logic pal_wr;
	logic stat_rd;

	assign colour  = colour_cfg_reg;
	assign idx_wr  = io_req.wr && io_req.addr == (colour ?
		tgd_pkg::COLOR_CRTC_INDEX : tgd_pkg::MONO_CRTC_INDEX); // RL1
	assign data_wr = io_req.wr && io_req.addr == (colour ?
		tgd_pkg::COLOR_CRTC_DATA : tgd_pkg::MONO_CRTC_DATA); // RL2
	assign data_rd = io_req.rd && io_req.addr == (colour ?
		tgd_pkg::COLOR_CRTC_DATA : tgd_pkg::MONO_CRTC_DATA); // RL2
	assign ctrl_wr = io_req.wr && !colour &&
		io_req.addr == tgd_pkg::MONO_DISP_CONTROL;
	assign mode_wr = io_req.wr && colour &&
		io_req.addr == tgd_pkg::COLOR_MODE_SELECT;
	assign pal_wr  = io_req.wr && colour &&
		io_req.addr == tgd_pkg::COLOR_PAL_SELECT;
	assign stat_rd = io_req.rd && io_req.addr == (colour ?
		tgd_pkg::COLOR_DISP_STATUS : tgd_pkg::MONO_DISP_STATUS);

	// ==============================================================
	// Register file
	logic [4:0] index_reg;
	logic [7:0] crtc_reg [tgd_pkg::NUM_CRTC];
	logic [7:0] ctrl_reg;
	logic [5:0] mode_reg;
	logic [5:0] pal_reg;
	logic [13:0] char_addr;

	always_ff @(posedge clock or posedge reset)
		if (reset)
			index_reg <= 5'h00;
		else if (idx_wr)
			index_reg <= io_req.wdata[4:0]; // RL1

	// The pen latch is hardware-owned, so host writes there are dropped.
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			for (int i = 0; i < tgd_pkg::NUM_CRTC; i++)
				crtc_reg[i] <= 8'h00;
		end
		else
		begin
			if (data_wr && index_reg < tgd_pkg::IX_PEN_HIGH)
				crtc_reg[index_reg] <= io_req.wdata; // RL3 RL4
			if (pen_rise)
			begin
				crtc_reg[tgd_pkg::IX_PEN_HIGH] <= {2'b00, char_addr[13:8]};
				crtc_reg[tgd_pkg::IX_PEN_LOW]  <= char_addr[7:0];
			end
		end

	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			ctrl_reg <= tgd_pkg::CTRL_RESET;
			mode_reg <= tgd_pkg::MODE_RESET;
			pal_reg  <= tgd_pkg::PAL_RESET;
		end
		else
		begin
			if (ctrl_wr)
				ctrl_reg <= io_req.wdata; // RL5
			if (mode_wr)
				mode_reg <= io_req.wdata[5:0]; // RL10
			if (pal_wr)
				pal_reg <= io_req.wdata[5:0]; // RL15
		end

	// Write-only ports and unreadable timing registers answer zero.
	always_ff @(posedge clock or posedge reset)
		if (reset)
			io_rdata <= 8'h00;
		else if (data_rd && index_reg >= tgd_pkg::IX_CURSOR_HIGH &&
			index_reg <= tgd_pkg::IX_PEN_LOW)
			io_rdata <= crtc_reg[index_reg]; // RL2
		else if (stat_rd && colour)
			io_rdata <= {4'h0, video.vsync, 2'b00, !video.blank}; // RL19
		else if (stat_rd)
			io_rdata <= {4'h0, video.irgb != 4'h0, ctrl_reg[0],
				video.irgb != 4'h0, video.hsync}; // RL9
		else
			io_rdata <= 8'h00;

	// ==============================================================
	// Raster counters
	logic [7:0]  htot;
	logic [7:0]  hdisp;
	logic [7:0]  hsp;
	logic [6:0]  vtot;
	logic [4:0]  vadj;
	logic [6:0]  vdisp;
	logic [6:0]  vsp;
	logic [4:0]  max_scan;
	logic        graphics;
	logic        wide;
	logic [3:0]  pix_reg;
	logic        slot_end;
	logic [7:0]  h_reg;
	logic        line_end;
	logic [4:0]  scan_reg;
	logic [4:0]  scan_next;
	logic [6:0]  row_reg;
	logic [6:0]  row_next;
	logic [4:0]  adj_reg;
	logic [4:0]  adj_next;
	tgd_pkg::tgd_vphase_e phase_reg;
	tgd_pkg::tgd_vphase_e phase_next;
	logic        frame_end;
	logic        row_end;
	logic [4:0]  vs_cnt_reg;
	logic [13:0] row_start_reg;
	logic [4:0]  frame_reg;

	assign htot     = crtc_reg[tgd_pkg::IX_HORIZ_TOTAL];
	assign hdisp    = crtc_reg[tgd_pkg::IX_HORIZ_DISPLAYED];
	assign hsp      = crtc_reg[tgd_pkg::IX_HORIZ_SYNC_POS];
	assign vtot     = crtc_reg[tgd_pkg::IX_VERT_TOTAL][6:0];
	assign vadj     = crtc_reg[tgd_pkg::IX_VERT_ADJUST][4:0];
	assign vdisp    = crtc_reg[tgd_pkg::IX_VERT_DISPLAYED][6:0];
	assign vsp      = crtc_reg[tgd_pkg::IX_VERT_SYNC_POS][6:0];
	assign max_scan = crtc_reg[tgd_pkg::IX_MAX_SCAN_LINE][4:0];
	assign graphics = mode_reg[tgd_pkg::MS_GRAPHICS] |
		mode_reg[tgd_pkg::MS_HIRES]; // RL11 RL13
	// Forty-column text doubles every pixel, so a cell lasts 16 clocks.
	assign wide     = colour && !mode_reg[tgd_pkg::MS_80COL] &&
		!graphics; // RL10
	assign slot_end = pix_reg == (wide ? 4'hf : 4'h7);
	assign line_end = slot_end && h_reg == htot; // RL23

	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			pix_reg <= 4'h0;
			h_reg   <= 8'h00;
		end
		else
		begin
			pix_reg <= slot_end ? 4'h0 : pix_reg + 4'h1;
			if (line_end)
				h_reg <= 8'h00; // RL23
			else if (slot_end)
				h_reg <= h_reg + 8'h01;
		end

	always_comb
	begin
		scan_next  = scan_reg;
		row_next   = row_reg;
		adj_next   = adj_reg;
		phase_next = phase_reg;
		frame_end  = 1'b0;
		row_end    = 1'b0;
		case (phase_reg)
			tgd_pkg::TGD_V_ROWS:
				if (scan_reg == max_scan)
				begin
					scan_next = 5'h00;
					row_end   = 1'b1;
					if (row_reg == vtot)
					begin
						row_next = 7'h00;
						adj_next = 5'h00;
						if (vadj == 5'h00)
							frame_end = 1'b1;
						else
							phase_next = tgd_pkg::TGD_V_ADJUST;
					end
					else
						row_next = row_reg + 7'h01;
				end
				else
					scan_next = scan_reg + 5'h01;
			tgd_pkg::TGD_V_ADJUST:
				if (adj_reg == vadj - 5'h01)
				begin
					phase_next = tgd_pkg::TGD_V_ROWS;
					frame_end  = 1'b1;
				end
				else
					adj_next = adj_reg + 5'h01;
			default:
				phase_next = tgd_pkg::TGD_V_ROWS;
		endcase
	end

	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			scan_reg      <= 5'h00;
			row_reg       <= 7'h00;
			adj_reg       <= 5'h00;
			phase_reg     <= tgd_pkg::TGD_V_ROWS;
			vs_cnt_reg    <= 5'h00;
			row_start_reg <= 14'h0000;
			frame_reg     <= 5'h00;
		end
		else if (line_end)
		begin
			scan_reg  <= scan_next;
			row_reg   <= row_next;
			adj_reg   <= adj_next;
			phase_reg <= phase_next;
			if ((row_end || frame_end) && row_next == vsp &&
				phase_next == tgd_pkg::TGD_V_ROWS)
				vs_cnt_reg <= tgd_pkg::VSYNC_LINES; // RL23
			else if (vs_cnt_reg != 5'h00)
				vs_cnt_reg <= vs_cnt_reg - 5'h01;
			if (frame_end)
			begin
				row_start_reg <= {crtc_reg[tgd_pkg::IX_START_HIGH][5:0],
					crtc_reg[tgd_pkg::IX_START_LOW]}; // RL4
				frame_reg <= frame_reg + 5'h01;
			end
			else if (row_end)
				row_start_reg <= row_start_reg + {6'h00, hdisp};
		end

	// ==============================================================
	// Cell fetch from the display buffer
	logic [7:0]  vbuf [tgd_pkg::BUF_BYTES];
	logic [8:0]  hs_end;
	logic        hs_now;
	logic        de_now;
	logic        cur_now;
	logic [13:0] cursor_addr;
	logic [13:0] text_addr;
	logic [13:0] gfx_addr;
	logic [7:0]  attr_reg;
	logic [7:0]  gfx_reg;
	logic        slot_de_reg;
	logic        slot_hs_reg;
	logic        slot_vs_reg;
	logic        slot_cur_reg;
	logic        slot_last_reg;

	assign hs_end      = {1'b0, hsp} +
		{5'h00, crtc_reg[tgd_pkg::IX_HORIZ_SYNC_W][3:0]};
	assign hs_now      = h_reg >= hsp && {1'b0, h_reg} < hs_end; // RL23
	assign de_now      = phase_reg == tgd_pkg::TGD_V_ROWS &&
		h_reg < hdisp && row_reg < vdisp; // RL23
	assign char_addr   = row_start_reg + {6'h00, h_reg};
	assign cursor_addr = {crtc_reg[tgd_pkg::IX_CURSOR_HIGH][5:0],
		crtc_reg[tgd_pkg::IX_CURSOR_LOW]};
	assign cur_now     = char_addr == cursor_addr &&
		scan_reg >= crtc_reg[tgd_pkg::IX_CURSOR_FIRST][4:0] &&
		scan_reg <= crtc_reg[tgd_pkg::IX_CURSOR_LAST][4:0] &&
		frame_reg[tgd_pkg::CURSOR_BLINK_BIT]; // RL23
	// The mono adapter sees the low 4 KB; colour text spans all 16 KB.
	assign text_addr   = colour ? {char_addr[12:0], 1'b0} :
		{2'b00, char_addr[10:0], 1'b0}; // RL20 RL21
	// Graphics places even scan lines in the low half, odd in the high.
	assign gfx_addr    = {scan_reg[0], char_addr[12:0]}; // RL20

	always_ff @(posedge clock)
	begin
		if (mem_wr)
			vbuf[mem_addr] <= mem_wdata;
		mem_rdata <= vbuf[mem_addr];
	end

	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			font_code     <= 8'h00;
			font_line     <= 5'h00;
			attr_reg      <= 8'h00;
			gfx_reg       <= 8'h00;
			slot_de_reg   <= 1'b0;
			slot_hs_reg   <= 1'b0;
			slot_vs_reg   <= 1'b0;
			slot_cur_reg  <= 1'b0;
			slot_last_reg <= 1'b0;
		end
		else if (slot_end)
		begin
			font_code     <= vbuf[text_addr]; // RL21
			attr_reg      <= vbuf[text_addr | 14'h0001]; // RL21
			gfx_reg       <= vbuf[gfx_addr];
			font_line     <= scan_reg;
			slot_de_reg   <= de_now;
			slot_hs_reg   <= hs_now;
			slot_vs_reg   <= vs_cnt_reg != 5'h00;
			slot_cur_reg  <= cur_now && de_now;
			slot_last_reg <= scan_reg == max_scan;
		end

	// ==============================================================
	// Pixel output
	logic [2:0] bit_sel;
	logic       blink_mode;
	logic       text_on;
	logic       blank_attr;
	logic [7:0] gfx_shift;
	logic [3:0] colour_txt;
	logic [3:0] pix_c;

	assign bit_sel    = wide ? pix_reg[3:1] : pix_reg[2:0];
	assign blink_mode = colour ? mode_reg[tgd_pkg::MS_BLINK] : 1'b1; // RL14
	assign text_on    = ((font_bits[3'd7 - bit_sel] ||
		(attr_reg[6:0] == 7'h01 && slot_last_reg)) &&
		!(blink_mode && attr_reg[7] &&
		frame_reg[tgd_pkg::CHAR_BLINK_BIT])) || slot_cur_reg; // RL22
	assign blank_attr = attr_reg[6:0] == 7'h00; // RL22
	assign gfx_shift  = gfx_reg << {pix_reg[2:1], 1'b0};
	assign colour_txt = text_irgb(attr_reg, text_on, blink_mode); // RL22

	always_comb
	begin
		pix_c = 4'h0;
		if (!slot_de_reg)
			pix_c = (slot_hs_reg || slot_vs_reg || !colour) ? 4'h0 :
				pal_reg[3:0]; // RL15
		else if (colour)
		begin
			if (mode_reg[tgd_pkg::MS_HIRES])
				pix_c = gfx_reg[3'd7 - pix_reg[2:0]] ? 4'hf : 4'h0; // RL13
			else if (graphics)
				pix_c = pal_irgb(gfx_shift[7:6], pal_reg); // RL16 RL17 RL18
			else
				pix_c = colour_txt;
			if (mode_reg[tgd_pkg::MS_BW])
				pix_c = {pix_c[3], {3{pix_c[2:0] != 3'b000}}}; // RL11
		end
		else if (ctrl_reg[tgd_pkg::MC_COLOR_EN])
			pix_c = colour_txt; // RL5
		else if (text_on && !blank_attr)
			pix_c = {ctrl_reg[tgd_pkg::MC_FG_FULL], 3'b111}; // RL6
		else if (ctrl_reg[tgd_pkg::MC_BG_EN] && attr_reg[6:4] != 3'b000)
			pix_c = {ctrl_reg[tgd_pkg::MC_BG_FULL], 3'b111}; // RL6 RL8
		if (colour ? !mode_reg[tgd_pkg::MS_VIDEO_EN] :
			!ctrl_reg[tgd_pkg::MC_VIDEO_EN])
			pix_c = 4'h0; // RL7 RL12
	end

	always_ff @(posedge clock or posedge reset)
		if (reset)
			video <= '0;
		else
		begin
			video.irgb  <= pix_c;
			video.hsync <= slot_hs_reg;
			video.vsync <= slot_vs_reg;
			video.blank <= !slot_de_reg &&
				(colour || ctrl_reg[tgd_pkg::MC_BLANK_EN]); // RL8
		end

	// ==============================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	chk_index_write: assert property ( // RL1
		idx_wr |=> index_reg == $past(io_req.wdata[4:0]))
		else $error("index port write not captured");
	chk_cursor_read: assert property ( // RL2
		data_rd && index_reg == tgd_pkg::IX_CURSOR_LOW
		|=> io_rdata == $past(crtc_reg[tgd_pkg::IX_CURSOR_LOW]))
		else $error("cursor register read mismatch");
	chk_ctrl_hidden: assert property ( // RL5
		io_req.rd && io_req.addr == tgd_pkg::MONO_DISP_CONTROL
		|=> io_rdata == 8'h00)
		else $error("write-only control register readable");
	chk_mono_gate: assert property ( // RL7
		!colour && !ctrl_reg[tgd_pkg::MC_VIDEO_EN] |=> video.irgb == 4'h0)
		else $error("mono video not gated off");
	chk_mode_write: assert property ( // RL10
		mode_wr |=> mode_reg == $past(io_req.wdata[5:0]))
		else $error("mode register write lost");
	chk_colour_gate: assert property ( // RL12
		colour && !mode_reg[tgd_pkg::MS_VIDEO_EN] ##1 colour
		|-> video.irgb == 4'h0)
		else $error("colour video not gated off");
	chk_vsync_status: assert property ( // RL19
		stat_rd && colour |=> io_rdata[3] == $past(video.vsync) &&
		io_rdata[2:1] == 2'b00)
		else $error("colour status vsync wrong");
	chk_line_wrap: assert property ( // RL23
		line_end |=> h_reg == 8'h00 ##1 h_reg == 8'h00 [*7])
		else $error("character counter did not wrap");
	chk_pen_latch: assert property ( // RL4
		pen_rise |=> crtc_reg[tgd_pkg::IX_PEN_LOW] == $past(char_addr[7:0]))
		else $error("light pen address not latched");
endmodule

// ### bench/tgd_host_model.sv
// Host processor model issuing I/O port cycles to the display control.
`timescale 1ns/1ps
module tgd_host_model (
	input  wire logic            clock,
	output tgd_pkg::tgd_io_req_s io_req,
	input  wire logic [7:0]      io_rdata
);
	initial io_req = '0;

	// ==============================================================
	// Port cycles
	// Each request is held for exactly one taken edge, then released.
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clock);
		io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clock);
		io_req <= '0;
	endtask

	// Read data is registered, so it is sampled half a cycle after the take.
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clock);
		io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clock);
		io_req <= '0;
		@(negedge clock);
		d = io_rdata;
	endtask

	// Index first, then the data port.
	task automatic crtc_wr(input logic [9:0] b, input logic [4:0] ix,
		input logic [7:0] v);
		wr(b, {3'b000, ix});
		wr(b + 10'h001, v);
	endtask

	task automatic crtc_rd(input logic [9:0] b, input logic [4:0] ix,
		output logic [7:0] d);
		wr(b, {3'b000, ix});
		rd(b + 10'h001, d);
	endtask
endmodule

// ### bench/tb.sv
// Self-checking testbench for the text and graphics display control.
`timescale 1ns/1ps
module tb;
	logic                 clock;
	logic                 reset;
	logic                 colour_strap;
	logic                 light_pen;
	tgd_pkg::tgd_io_req_s io_req;
	logic [7:0]           io_rdata;
	logic [13:0]          mem_addr;
	logic                 mem_wr;
	logic [7:0]           mem_wdata;
	logic [7:0]           mem_rdata;
	logic [7:0]           font_code;
	logic [4:0]           font_line;
	logic [7:0]           font_bits;
	tgd_pkg::tgd_video_s  video;
	int                   err_total;
	int                   tests_run;
	logic [7:0]           rv;

	tgd_display_control u_dut (
		.clock        (clock),
		.reset        (reset),
		.colour_strap (colour_strap),
		.light_pen    (light_pen),
		.io_req       (io_req),
		.io_rdata     (io_rdata),
		.mem_addr     (mem_addr),
		.mem_wr       (mem_wr),
		.mem_wdata    (mem_wdata),
		.mem_rdata    (mem_rdata),
		.font_code    (font_code),
		.font_line    (font_line),
		.font_bits    (font_bits),
		.video        (video)
	);

	tgd_host_model u_host (
		.clock    (clock),
		.io_req   (io_req),
		.io_rdata (io_rdata)
	);

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// ==============================================================
	// Shared tasks
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic do_reset(input logic strap);
		@(posedge clock);
		reset <= 1'b1;
		colour_strap <= strap;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		repeat (6) @(posedge clock);
	endtask

	// Line of 10 cells, 21 lines a frame, two displayed rows.
	task automatic setup(input logic [9:0] ix);
		logic [7:0] r [16];
		r = '{8'h09, 8'h06, 8'h07, 8'h02, 8'h09, 8'h01, 8'h02, 8'h02,
			8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h3f, 8'hff};
		for (int i = 0; i < 16; i++)
			u_host.crtc_wr(ix, i[4:0], r[i]);
		u_host.crtc_rd(ix, 5'h0f, rv);
		check("cursor_low", {8'h00, rv}, 16'h00ff);
		u_host.crtc_rd(ix, 5'h01, rv);
		check("horiz_disp_read", {8'h00, rv}, 16'h0000);
	endtask

	// Counts cycles until the chosen sync reaches the given level.
	task automatic span(input logic v, input logic lvl, output int c);
		c = 0;
		while ((v ? video.vsync : video.hsync) !== lvl && c < 4000)
		begin
			@(negedge clock);
			c++;
		end
	endtask

	task automatic fill(input logic [7:0] ev, input logic [7:0] od);
		for (int i = 0; i < 128; i++)
		begin
			@(posedge clock);
			mem_addr <= {i[6], 7'h00, i[5:0]};
			mem_wdata <= i[0] ? od : ev;
			mem_wr <= 1'b1;
		end
		@(posedge clock);
		mem_wr <= 1'b0;
	endtask

	task automatic mem_chk(input logic [13:0] a, input logic [7:0] e);
		@(posedge clock);
		mem_addr <= a;
		@(posedge clock);
		@(negedge clock);
		check("mem_rdata", {8'h00, mem_rdata}, {8'h00, e});
	endtask

	// Every displayed pixel of a settled frame must show one colour.
	task automatic pix(input logic [9:0] ca, input logic [7:0] cv,
		input logic [5:0] pal, input logic [7:0] ev, input logic [7:0] od,
		input logic [7:0] fb, input logic [3:0] ex);
		int n;
		int bad;
		logic [3:0] seen;
		u_host.wr(ca, cv);
		u_host.wr(tgd_pkg::COLOR_PAL_SELECT, {2'b00, pal});
		font_bits <= fb;
		fill(ev, od);
		repeat (1700) @(posedge clock);
		n = 0;
		bad = 0;
		seen = ex;
		repeat (1700)
		begin
			@(negedge clock);
			if (video.blank === 1'b0)
			begin
				n++;
				if (video.irgb !== ex)
					seen = video.irgb;
				if (font_code !== ev || font_line[4:1] !== 4'h0)
					bad++;
			end
		end
		check("irgb", {12'h000, seen}, {12'h000, ex});
		check("display_shown", 16'(n > 0), 16'h0001);
		check("font_code_line", 16'(bad), 16'h0000);
	endtask

	// ==============================================================
	// Scenarios
	task automatic sync_case(input logic [7:0] mode, input int k);
		int c;
		int w;
		int p;
		u_host.wr(tgd_pkg::COLOR_MODE_SELECT, mode);
		span(1'b0, 1'b1, c);
		span(1'b0, 1'b0, c);
		span(1'b0, 1'b1, c);
		span(1'b0, 1'b0, w);
		span(1'b0, 1'b1, p);
		check("hsync_width", 16'(w), 16'(2 * k));
		check("line_clocks", 16'(w + p), 16'(10 * k));
		span(1'b1, 1'b0, c);
		span(1'b1, 1'b1, c);
		span(1'b1, 1'b0, w);
		span(1'b1, 1'b1, p);
		check("vsync_width", 16'(w), 16'(160 * k));
		check("frame_clocks", 16'(w + p), 16'(210 * k));
		u_host.rd(tgd_pkg::COLOR_DISP_STATUS, rv);
		check("colour_status", {8'h00, rv}, 16'h0008);
	endtask

	task automatic colour_case();
		do_reset(1'b1);
		setup(tgd_pkg::COLOR_CRTC_INDEX);
		u_host.rd(tgd_pkg::MONO_CRTC_DATA, rv);
		check("mono_port_in_colour", {8'h00, rv}, 16'h0000);
		u_host.rd(tgd_pkg::COLOR_MODE_SELECT, rv);
		check("mode_read", {8'h00, rv}, 16'h0000);
		sync_case(8'h09, 8);
		sync_case(8'h08, 16);
	endtask

	task automatic colour_pixels(input logic [9:0] m);
		pix(m, 8'h09, 6'h00, 8'h41, 8'h07, 8'hff, 4'h7);
		mem_chk(14'h2001, 8'h07);
		mem_chk(14'h0000, 8'h41);
		pix(m, 8'h09, 6'h00, 8'h41, 8'h0f, 8'hff, 4'hf);
		pix(m, 8'h09, 6'h00, 8'h41, 8'h70, 8'h00, 4'h7);
		pix(m, 8'h09, 6'h00, 8'h41, 8'h00, 8'hff, 4'h0);
		pix(m, 8'h01, 6'h00, 8'h41, 8'h07, 8'hff, 4'h0);
		pix(m, 8'h0a, 6'h00, 8'h55, 8'h55, 8'h00, 4'h2);
		pix(m, 8'h0a, 6'h00, 8'haa, 8'haa, 8'h00, 4'h4);
		pix(m, 8'h0a, 6'h00, 8'hff, 8'hff, 8'h00, 4'h6);
		pix(m, 8'h0a, 6'h20, 8'h55, 8'h55, 8'h00, 4'h3);
		pix(m, 8'h0a, 6'h20, 8'haa, 8'haa, 8'h00, 4'h5);
		pix(m, 8'h0a, 6'h30, 8'hff, 8'hff, 8'h00, 4'hf);
		pix(m, 8'h0a, 6'h03, 8'h00, 8'h00, 8'h00, 4'h3);
		pix(m, 8'h1a, 6'h00, 8'hff, 8'hff, 8'h00, 4'hf);
		pix(m, 8'h1a, 6'h00, 8'h00, 8'h00, 8'hff, 4'h0);
	endtask

	task automatic mono_case();
		int c;
		int b;
		logic [9:0] m;
		m = tgd_pkg::MONO_DISP_CONTROL;
		do_reset(1'b0);
		setup(tgd_pkg::MONO_CRTC_INDEX);
		u_host.rd(tgd_pkg::COLOR_CRTC_DATA, rv);
		check("colour_port_in_mono", {8'h00, rv}, 16'h0000);
		span(1'b0, 1'b1, c);
		u_host.rd(tgd_pkg::MONO_DISP_STATUS, rv);
		check("mono_hsync_high", {15'h0000, rv[0]}, 16'h0001);
		span(1'b0, 1'b0, c);
		u_host.rd(tgd_pkg::MONO_DISP_STATUS, rv);
		check("mono_hsync_low", {15'h0000, rv[0]}, 16'h0000);
		pix(m, 8'h1a, 6'h00, 8'h41, 8'h07, 8'hff, 4'hf);
		pix(m, 8'h18, 6'h00, 8'h41, 8'h07, 8'hff, 4'h7);
		pix(m, 8'h10, 6'h00, 8'h41, 8'h07, 8'hff, 4'h0);
		u_host.wr(m, 8'h0a);
		repeat (2) @(posedge clock);
		b = 0;
		repeat (1700)
		begin
			@(negedge clock);
			b += int'(video.blank === 1'b1);
		end
		check("blank_disabled", 16'(b), 16'h0000);
		u_host.rd(m, rv);
		check("control_read", {8'h00, rv}, 16'h0000);
		@(posedge clock);
		light_pen <= 1'b1;
		repeat (6) @(posedge clock);
		u_host.crtc_wr(tgd_pkg::MONO_CRTC_INDEX, 5'h10, 8'hff);
		u_host.crtc_rd(tgd_pkg::MONO_CRTC_INDEX, 5'h10, rv);
		check("pen_high_ro", {8'h00, rv}, 16'h0000);
	endtask

	// ==============================================================
	// Main sequence and watchdog
	initial
	begin
		err_total = 0;
		tests_run = 0;
		reset = 1'b1;
		colour_strap = 1'b1;
		light_pen = 1'b0;
		mem_addr = 14'h0000;
		mem_wr = 1'b0;
		mem_wdata = 8'h00;
		font_bits = 8'h00;
		colour_case();
		colour_pixels(tgd_pkg::COLOR_MODE_SELECT);
		mono_case();
		summarize();
	end

	initial
	begin
		repeat (95000) @(posedge clock);
		err_total++;
		summarize();
	end
endmodule
